// ---- src/sps_pkg.sv ----
// constants, register map and types of the serial port status flag block
package sps_pkg;

	// register map, byte addresses on the 3-bit register port
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_CTRL2  = 3'h1;
	localparam logic [2:0] ADDR_CTRL3  = 3'h2;
	localparam logic [2:0] ADDR_DATA   = 3'h3;
	localparam logic [2:0] ADDR_CTRL1  = 3'h4;

	// status register bit positions
	localparam int ST_TX_EMPTY  = 7;
	localparam int ST_TX_DONE   = 6;
	localparam int ST_RX_FULL   = 5;
	localparam int ST_IDLE      = 4;
	localparam int ST_OVERRUN   = 3;
	localparam int ST_NOISE     = 2;
	localparam int ST_FRAMING   = 1;
	localparam int ST_PARITY    = 0;

	// control bit positions
	localparam int C1_NINE_BIT  = 4;
	localparam int C1_IDLE_TYPE = 2;
	localparam int C1_PAR_EN    = 1;
	localparam int C1_PAR_ODD   = 0;
	localparam int C2_TX_EN     = 3;
	localparam int C2_BREAK     = 0;
	localparam int C3_RX_BIT8   = 7;
	localparam int C3_TX_BIT8   = 6;

	// reset values
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'hC0;

	// receiver timing: 16 samples per bit time
	localparam int CLK_HZ      = 100_000_000;
	localparam int BAUD_RATE   = 115_200;
	localparam int OVERSAMPLE  = 16;
	localparam int OS_DIV      = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
	localparam logic [3:0] PH_START_FIRST = 4'h4;
	localparam logic [3:0] PH_START_LAST  = 4'hA;
	localparam logic [3:0] PH_VOTE_FIRST  = 4'h7;
	localparam logic [3:0] PH_VOTE_LAST   = 4'h9;
	localparam logic [3:0] PH_LAST        = 4'hF;

	// character length in bit times, start and stop included
	localparam logic [3:0] CHAR_BITS_8 = 4'hA;
	localparam logic [3:0] CHAR_BITS_9 = 4'hB;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} sps_rx_state_t;

endpackage : sps_pkg

// ---- src/sps_status_flags.sv ----
// serial port status flags with a small receiver and transmit handshakes
//
// Behaviour
// - status register is read only; writes never change a flag.
// - transmit buffer empty sets at reset and when buffer moves to shifter.
// - status read with buffer empty set, then data write, clears it.
// - transmit complete sets at reset and when buffer empty and line idle.
// - after status read, data write, enable rise or break write clears it.
// - receive full sets when a character enters the receive data register.
// - eight-bit mode: status read then data read clears receive full.
// - nine-bit mode: both data and control three reads needed to clear.
// - idle sets after activity when line high for ten or eleven bits.
// - idle type zero counts high bits from just after the start bit.
// - idle type one counts high bits only after the stop bit.
// - idle clears by status then data read; sets once per received character.
// - overrun sets when a character arrives unread; new character discarded.
// - status read then data read clears overrun.
// - seven start samples, three per bit; disagreement sets noise with full.
// - status read then data read clears noise.
// - framing error sets with receive full when stop bit samples low.
// - status read then data read clears framing error.
// - parity error sets with receive full when enabled parity mismatches.
// - status read then data read clears parity error.
// - nine-bit select gives nine data bits, extra bit above the data MSB.
module sps_status_flags (
	input  wire logic       i_clk,      // 100 MHz system clock
	input  wire logic       i_reset_n,  // asynchronous reset, active low
	input  wire logic [2:0] i_addr,     // register address
	input  wire logic [7:0] i_wdata,    // register write data
	input  wire logic       i_wr,       // write strobe
	input  wire logic       i_rd,       // read strobe
	output logic      [7:0] o_rdata_q,  // read data, cycle after strobe
	input  wire logic       i_rxd,      // receive line from remote device
	input  wire logic       i_tx_load,  // buffer moved into shifter, pulse
	input  wire logic       i_tx_busy,  // data, preamble or break on line
	output logic      [7:0] o_tx_data,  // transmit buffer contents
	output logic            o_tx_bit8,  // ninth transmit bit
	output logic            o_tx_write, // buffer written, pulse
	output logic            o_tx_enable,// transmitter enable
	output logic            o_send_break,// break queue control
	output logic            o_preamble  // preamble queued, pulse
);

	function automatic logic hit(input logic [2:0] a, input logic [2:0] t);
		return a == t;
	endfunction : hit

	// register port decode
	logic st_rd, d_rd, c3_rd, d_wr, c1_wr, c2_wr, c3_wr;
	assign st_rd = i_rd & hit(i_addr, sps_pkg::ADDR_STATUS);
	assign d_rd  = i_rd & hit(i_addr, sps_pkg::ADDR_DATA);
	assign c3_rd = i_rd & hit(i_addr, sps_pkg::ADDR_CTRL3);
	assign d_wr  = i_wr & hit(i_addr, sps_pkg::ADDR_DATA);
	assign c1_wr = i_wr & hit(i_addr, sps_pkg::ADDR_CTRL1);
	assign c2_wr = i_wr & hit(i_addr, sps_pkg::ADDR_CTRL2);
	assign c3_wr = i_wr & hit(i_addr, sps_pkg::ADDR_CTRL3);

	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic       tx_bit8_q;
	logic       nine_bit;
	logic       te_rise;
	logic       brk_one;
	assign nine_bit = ctrl1_q[sps_pkg::C1_NINE_BIT];
	assign te_rise  = c2_wr & i_wdata[sps_pkg::C2_TX_EN]
		& ~ctrl2_q[sps_pkg::C2_TX_EN];
	assign brk_one  = c2_wr & i_wdata[sps_pkg::C2_BREAK];

	// control registers; the status address has no storage at all
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl1_q   <= sps_pkg::CTRL_RESET;
			ctrl2_q   <= sps_pkg::CTRL_RESET;
			tx_bit8_q <= 1'b0;
		end else begin
			if (c1_wr) ctrl1_q <= i_wdata;
			if (c2_wr) ctrl2_q <= i_wdata;
			if (c3_wr) tx_bit8_q <= i_wdata[sps_pkg::C3_TX_BIT8];
		end
	end

	assign o_tx_enable  = ctrl2_q[sps_pkg::C2_TX_EN];
	assign o_send_break = ctrl2_q[sps_pkg::C2_BREAK];
	assign o_tx_bit8    = tx_bit8_q;

	// transmit side strobes toward the shifter
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx_data  <= 8'h00;
			o_tx_write <= 1'b0;
			o_preamble <= 1'b0;
		end else begin
			o_tx_write <= d_wr;
			o_preamble <= te_rise;
			if (d_wr) o_tx_data <= i_wdata;
		end
	end

	// receive line synchroniser, idles high
	logic rxd_meta_q, rxd_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rxd_meta_q <= 1'b1;
			rxd_q      <= 1'b1;
		end else begin
			rxd_meta_q <= i_rxd;
			rxd_q      <= rxd_meta_q;
		end
	end

	// sample tick divider
	logic [7:0] div_q;
	logic       os_tick;
	assign os_tick = div_q == 8'(sps_pkg::OS_DIV - 1);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) div_q <= 8'h00;
		else if (os_tick) div_q <= 8'h00;
		else div_q <= div_q + 8'h01;
	end

	// receiver sampling state
	sps_pkg::sps_rx_state_t state_q;
	logic [3:0] phase_q;
	logic [2:0] ones_q, nsamp_q;
	logic [3:0] bitn_q;
	logic [8:0] shift_q;
	logic       noise_q;
	logic       in_win, bit_end, bit_val, bit_noisy;
	logic [3:0] ndata;
	logic [3:0] char_bits;
	logic [8:0] shift_nx;

	// start bit takes a wider window so seven samples land in it
	assign in_win = (state_q == sps_pkg::RX_START)
		? (phase_q >= sps_pkg::PH_START_FIRST
			&& phase_q <= sps_pkg::PH_START_LAST)
		: (phase_q >= sps_pkg::PH_VOTE_FIRST
			&& phase_q <= sps_pkg::PH_VOTE_LAST);
	assign bit_end   = os_tick && state_q != sps_pkg::RX_IDLE
		&& phase_q == sps_pkg::PH_LAST;
	assign bit_val   = {ones_q, 1'b0} > {1'b0, nsamp_q};
	assign bit_noisy = ones_q != 3'h0 && ones_q != nsamp_q;
	assign ndata     = nine_bit ? 4'h9 : 4'h8;
	assign char_bits = nine_bit ? sps_pkg::CHAR_BITS_9
		: sps_pkg::CHAR_BITS_8;
	assign shift_nx  = {bit_val, shift_q[8:1]};

	// character delivered to the flag logic, one cycle pulse
	logic       char_done_q, char_nf_q, char_fe_q, char_pf_q;
	logic [8:0] char_data_q;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= sps_pkg::RX_IDLE;
			phase_q <= 4'h0;
			ones_q  <= 3'h0;
			nsamp_q <= 3'h0;
			bitn_q  <= 4'h0;
			shift_q <= 9'h000;
			noise_q <= 1'b0;
		end else if (os_tick) begin
			phase_q <= phase_q + 4'h1;
			if (state_q != sps_pkg::RX_IDLE && in_win) begin
				nsamp_q <= nsamp_q + 3'h1;
				ones_q  <= ones_q + {2'b00, rxd_q};
			end
			unique case (state_q)
				sps_pkg::RX_IDLE: begin
					if (!rxd_q) begin
						state_q <= sps_pkg::RX_START;
						phase_q <= 4'h0;
						noise_q <= 1'b0;
						shift_q <= 9'h000;
					end
				end
				sps_pkg::RX_START: begin
					// a start bit voted high was a glitch
					if (bit_end) state_q <= bit_val
						? sps_pkg::RX_IDLE : sps_pkg::RX_DATA;
					if (bit_end) bitn_q <= 4'h0;
				end
				sps_pkg::RX_DATA: begin
					if (bit_end) begin
						shift_q <= shift_nx;
						bitn_q  <= bitn_q + 4'h1;
						if (bitn_q == ndata - 4'h1) state_q <= sps_pkg::RX_STOP;
					end
				end
				sps_pkg::RX_STOP: begin
					if (bit_end) state_q <= sps_pkg::RX_IDLE;
				end
			endcase
			if (bit_end) begin
				ones_q  <= 3'h0;
				nsamp_q <= 3'h0;
				noise_q <= noise_q | bit_noisy;
			end
		end
	end

	// frame result; parity bit is the last character bit when enabled
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			char_done_q <= 1'b0;
			char_nf_q   <= 1'b0;
			char_fe_q   <= 1'b0;
			char_pf_q   <= 1'b0;
			char_data_q <= 9'h000;
		end else begin
			char_done_q <= bit_end && state_q == sps_pkg::RX_STOP;
			if (bit_end && state_q == sps_pkg::RX_STOP) begin
				char_nf_q   <= noise_q | bit_noisy;
				char_fe_q   <= ~bit_val;
				char_pf_q   <= ctrl1_q[sps_pkg::C1_PAR_EN]
					&& ((^shift_q) != ctrl1_q[sps_pkg::C1_PAR_ODD]);
				char_data_q <= nine_bit ? shift_q
					: {1'b0, shift_q[8:1]};
			end
		end
	end

	// idle line bit counter; saturates at one character time
	logic [3:0] idle_cnt_q;
	logic       idle_bit;
	logic       idle_clr;
	assign idle_bit = (state_q == sps_pkg::RX_IDLE)
		? (os_tick && phase_q == sps_pkg::PH_LAST && rxd_q)
		: (bit_end && state_q != sps_pkg::RX_START && bit_val
			&& !ctrl1_q[sps_pkg::C1_IDLE_TYPE]);
	// type one throws away every in-frame bit, stop bit included
	assign idle_clr = bit_end && (state_q == sps_pkg::RX_START
		|| !bit_val || ctrl1_q[sps_pkg::C1_IDLE_TYPE]);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) idle_cnt_q <= 4'h0;
		else if (idle_clr) idle_cnt_q <= 4'h0;
		else if (idle_bit && idle_cnt_q < char_bits)
			idle_cnt_q <= idle_cnt_q + 4'h1;
	end

	// status flags and the read-then-access clearing
	logic       tx_empty_q, tx_done_q, rx_full_q, idle_q;
	logic       overrun_q, noise_f_q, framing_q, parity_q;
	logic [7:0] status;
	logic [7:0] arm_q;
	logic       seen_data_q, seen_c3_q;
	logic       idle_allow_q;
	logic       tx_req_q;
	logic       req_now, char_load, rx_clear, idle_set, tx_done_set;
	logic [8:0] rx_data_q;

	assign status = {tx_empty_q, tx_done_q, rx_full_q, idle_q,
		overrun_q, noise_f_q, framing_q, parity_q};
	assign req_now   = d_wr | te_rise | brk_one;
	assign char_load = char_done_q & ~rx_full_q;
	assign rx_clear  = nine_bit
		? ((d_rd & (seen_c3_q | c3_rd)) | (c3_rd & seen_data_q))
		: d_rd;
	assign idle_set  = idle_allow_q && idle_cnt_q >= char_bits;
	// a queued request holds off the idle test until the shifter reacts
	assign tx_done_set = tx_empty_q & ~i_tx_busy & ~tx_req_q & ~req_now;

	// flags seen set by the last status read; dropped once a flag clears
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			arm_q       <= 8'h00;
			seen_data_q <= 1'b0;
			seen_c3_q   <= 1'b0;
		end else if (st_rd) begin
			arm_q       <= status;
			seen_data_q <= 1'b0;
			seen_c3_q   <= 1'b0;
		end else begin
			arm_q       <= arm_q & status;
			seen_data_q <= seen_data_q | d_rd;
			seen_c3_q   <= seen_c3_q | c3_rd;
		end
	end

	// transmit flags; a set in the clearing cycle wins
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tx_empty_q <= sps_pkg::STATUS_RESET[sps_pkg::ST_TX_EMPTY];
			tx_done_q  <= sps_pkg::STATUS_RESET[sps_pkg::ST_TX_DONE];
			tx_req_q   <= 1'b0;
		end else begin
			tx_empty_q <= i_tx_load | (tx_empty_q
				& ~(d_wr & arm_q[sps_pkg::ST_TX_EMPTY]));
			tx_done_q  <= tx_done_set | (tx_done_q
				& ~(req_now & arm_q[sps_pkg::ST_TX_DONE]));
			if (req_now) tx_req_q <= 1'b1;
			else if (i_tx_busy) tx_req_q <= 1'b0;
		end
	end

	// receive flags; overrun keeps the old character and its errors
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_full_q <= 1'b0;
			overrun_q <= 1'b0;
			noise_f_q <= 1'b0;
			framing_q <= 1'b0;
			parity_q  <= 1'b0;
			rx_data_q <= 9'h000;
		end else begin
			rx_full_q <= char_load | (rx_full_q
				& ~(rx_clear & arm_q[sps_pkg::ST_RX_FULL]));
			overrun_q <= (char_done_q & rx_full_q) | (overrun_q
				& ~(d_rd & arm_q[sps_pkg::ST_OVERRUN]));
			noise_f_q <= (char_load & char_nf_q) | (noise_f_q
				& ~(d_rd & arm_q[sps_pkg::ST_NOISE]));
			framing_q <= (char_load & char_fe_q) | (framing_q
				& ~(d_rd & arm_q[sps_pkg::ST_FRAMING]));
			parity_q  <= (char_load & char_pf_q) | (parity_q
				& ~(d_rd & arm_q[sps_pkg::ST_PARITY]));
			if (char_load) rx_data_q <= char_data_q;
		end
	end

	// idle flag; only a fresh character re-arms it
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			idle_q       <= 1'b0;
			idle_allow_q <= 1'b0;
		end else begin
			idle_q <= idle_set | (idle_q
				& ~(d_rd & arm_q[sps_pkg::ST_IDLE]));
			if (char_load) idle_allow_q <= 1'b1;
			else if (idle_set) idle_allow_q <= 1'b0;
		end
	end

	// read data for one cycle only; writes to status land nowhere
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) o_rdata_q <= 8'h00;
		else if (!i_rd) o_rdata_q <= 8'h00;
		else if (hit(i_addr, sps_pkg::ADDR_STATUS)) o_rdata_q <= status;
		else if (hit(i_addr, sps_pkg::ADDR_DATA)) o_rdata_q <= rx_data_q[7:0];
		else if (hit(i_addr, sps_pkg::ADDR_CTRL3))
			o_rdata_q <= {rx_data_q[8], tx_bit8_q, 6'b00_0000};
		else if (hit(i_addr, sps_pkg::ADDR_CTRL2)) o_rdata_q <= ctrl2_q;
		else if (hit(i_addr, sps_pkg::ADDR_CTRL1)) o_rdata_q <= ctrl1_q;
		else o_rdata_q <= 8'h00;
	end

	// checks
	status_ro_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr && hit(i_addr, sps_pkg::ADDR_STATUS) && !char_done_q)
		|=> status[5:0] == $past(status[5:0]) || $past(idle_set))
		else $error("status write changed a receive flag");
	tx_empty_set_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) i_tx_load |=> tx_empty_q)
		else $error("buffer empty not set after load");
	tx_empty_clr_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (st_rd && tx_empty_q && !i_tx_load) ##1
		(!i_tx_load && !st_rd)[*2] ##0 (d_wr && !i_tx_load) |=> !tx_empty_q)
		else $error("buffer empty not cleared by armed data write");
	tx_done_set_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n)
		(tx_empty_q && !i_tx_busy && !tx_req_q && !req_now) |=> tx_done_q)
		else $error("transmit complete not set while idle");
	tx_done_clr_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (arm_q[sps_pkg::ST_TX_DONE]
		&& (te_rise || brk_one) && !st_rd) |=> !tx_done_q)
		else $error("transmit complete survived enable rise or break");
	rx_full_set_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) char_load |=> rx_full_q
		&& rx_data_q == $past(char_data_q))
		else $error("character not loaded with receive full");
	rx_clr8_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!nine_bit && d_rd && arm_q[sps_pkg::ST_RX_FULL] && !char_load)
		|=> !rx_full_q)
		else $error("receive full not cleared in eight-bit mode");
	rx_hold9_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(nine_bit && d_rd && !seen_c3_q && rx_full_q) |=> rx_full_q)
		else $error("receive full cleared without control three read");
	overrun_keep_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (char_done_q && rx_full_q) |=> overrun_q
		&& rx_data_q == $past(rx_data_q))
		else $error("overrun lost or old character replaced");
	idle_once_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!idle_allow_q && !idle_q) |=> !idle_q)
		else $error("idle set again without a new character");
	noise_with_full_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n)
		$rose(noise_f_q) |-> $rose(rx_full_q))
		else $error("noise set apart from receive full");
	arm_survive_a: assert property (@(posedge i_clk)
		disable iff (!i_reset_n) (i_rd && rx_full_q
		&& !arm_q[sps_pkg::ST_RX_FULL]) |=> rx_full_q)
		else $error("unseen receive full flag cleared");

endmodule : sps_status_flags

// ---- verif/sps_remote_dev.sv ----
// remote serial device model that drives the receive line of the block
module sps_remote_dev #(
	parameter int BIT_CLKS = 864  // clocks per bit time
) (
	input  wire logic i_clk,  // bench clock
	output logic      o_line  // serial line towards the receiver
);
	timeunit 1ns;
	timeprecision 1ps;

	// the line rests at mark level outside frames, as a real idle line does
	initial o_line = 1'h1;

	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
	endtask : hold

	// start bit, data lsb first, then stop; glitch drops one bit low briefly
	// so that only some of its samples disagree, which keeps its value
	task automatic send(input logic [8:0] bits, input int nbits,
			input logic stop, input int glitch);
		int mid;
		int gl;
		mid = BIT_CLKS / 2;
		// one sample period long, so exactly one vote sample sees it
		gl  = BIT_CLKS / 16;
		@(posedge i_clk);
		o_line <= 1'h0;
		hold(BIT_CLKS);
		for (int i = 0; i < nbits; i++) begin
			o_line <= bits[i];
			if (i == glitch) begin
				hold(mid);
				o_line <= 1'h0;
				hold(gl);
				o_line <= bits[i];
				hold(BIT_CLKS - mid - gl);
			end else begin
				hold(BIT_CLKS);
			end
		end
		o_line <= stop;
		hold(BIT_CLKS);
		o_line <= 1'h1;
	endtask : send
endmodule : sps_remote_dev

// ---- verif/tb_sps_status_flags.sv ----
// self-checking bench for the serial port status flag block
module tb_sps_status_flags;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int BIT = sps_pkg::OS_DIV * sps_pkg::OVERSAMPLE;
	localparam logic [2:0] ST = sps_pkg::ADDR_STATUS;
	localparam logic [2:0] DT = sps_pkg::ADDR_DATA;

	logic       i_clk;
	logic       i_reset_n;
	logic [2:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	logic [7:0] o_rdata_q;
	logic       rxd;
	logic       i_tx_load;
	logic       i_tx_busy;
	logic [7:0] o_tx_data;
	logic       o_tx_bit8;
	logic       o_tx_write;
	logic       o_tx_enable;
	logic       o_send_break;
	logic       o_preamble;
	logic [7:0] rv;
	int         mismatches;
	int         n_compared;

	sps_status_flags dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata_q(o_rdata_q),
		.i_rxd(rxd), .i_tx_load(i_tx_load), .i_tx_busy(i_tx_busy),
		.o_tx_data(o_tx_data), .o_tx_bit8(o_tx_bit8),
		.o_tx_write(o_tx_write), .o_tx_enable(o_tx_enable),
		.o_send_break(o_send_break), .o_preamble(o_preamble)
	);

	sps_remote_dev #(.BIT_CLKS(BIT)) dev (.i_clk(i_clk), .o_line(rxd));

	// 100 MHz clock
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [7:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s saw %h want %h", $time, what,
				seen, exp);
		end
	endtask : check

	// one-cycle strobes, launched right after a rising edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
	endtask : wr

	// read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		d = o_rdata_q;
	endtask : rd

	task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, m);
		logic [7:0] d;
		rd(a, d);
		check(d & m, e, "register read");
	endtask : chk_rd

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wait_clk

	// transmitter takes up a pending request and finishes it
	task automatic busy_blip;
		@(posedge i_clk);
		i_tx_busy <= 1'h1;
		wait_clk(3);
		i_tx_busy <= 1'h0;
		wait_clk(3);
	endtask : busy_blip

	task automatic t_tx;
		chk_rd(ST, 8'hC0, 8'hFF);
		wr(ST, 8'h00);
		wr(3'h6, 8'hFF);
		chk_rd(3'h7, 8'h00, 8'hFF);
		chk_rd(ST, 8'hC0, 8'hFF);
		wr(DT, 8'h5A);
		#1;
		check({7'h0, o_tx_write}, 8'h01, "tx write");
		check(o_tx_data, 8'h5A, "tx data");
		chk_rd(ST, 8'h00, 8'hFF);
		@(posedge i_clk);
		i_tx_busy <= 1'h1;
		i_tx_load <= 1'h1;
		@(posedge i_clk);
		i_tx_load <= 1'h0;
		chk_rd(ST, 8'h80, 8'hFF);
		@(posedge i_clk);
		i_tx_busy <= 1'h0;
		wait_clk(2);
		chk_rd(ST, 8'hC0, 8'hFF);
		wr(sps_pkg::ADDR_CTRL2, 8'h08);
		#1;
		check({7'h0, o_preamble}, 8'h01, "preamble");
		check({7'h0, o_tx_enable}, 8'h01, "tx enable");
		chk_rd(ST, 8'h80, 8'hFF);
		busy_blip();
		chk_rd(ST, 8'hC0, 8'hFF);
		wr(sps_pkg::ADDR_CTRL2, 8'h09);
		#1;
		check({7'h0, o_send_break}, 8'h01, "break");
		chk_rd(ST, 8'h80, 8'hFF);
		wr(sps_pkg::ADDR_CTRL2, 8'h08);
		busy_blip();
		chk_rd(ST, 8'hC0, 8'hFF);
	endtask : t_tx

	task automatic t_rx8;
		wr(sps_pkg::ADDR_CTRL1, 8'h00);
		dev.send(9'h0FF, 8, 1'h1, -1);
		wait_clk(150);
		chk_rd(ST, 8'hE0, 8'hFF);
		chk_rd(DT, 8'hFF, 8'hFF);
		chk_rd(ST, 8'hC0, 8'hFF);
		wait_clk(2 * BIT);
		chk_rd(ST, 8'hD0, 8'hFF);
		rd(DT, rv);
		wait_clk(2 * BIT);
		chk_rd(ST, 8'hC0, 8'hFF);
	endtask : t_rx8

	// stop bit and trailing ones must not count with the late idle type
	task automatic t_idle1;
		wr(sps_pkg::ADDR_CTRL1, 8'h04);
		dev.send(9'h0FF, 8, 1'h1, -1);
		wait_clk(150);
		chk_rd(ST, 8'hE0, 8'hFF);
		rd(DT, rv);
		wait_clk(5 * BIT);
		chk_rd(ST, 8'hC0, 8'hFF);
		wait_clk(6 * BIT);
		chk_rd(ST, 8'hD0, 8'hFF);
		rd(DT, rv);
	endtask : t_idle1

	task automatic t_overrun;
		wr(sps_pkg::ADDR_CTRL1, 8'h00);
		dev.send(9'h03C, 8, 1'h1, -1);
		dev.send(9'h0C3, 8, 1'h1, -1);
		wait_clk(150);
		chk_rd(ST, 8'hE8, 8'hFF);
		chk_rd(DT, 8'h3C, 8'hFF);
		chk_rd(ST, 8'hC0, 8'hFF);
	endtask : t_overrun

	// bad parity, a glitched bit and a low stop bit in one frame
	task automatic t_errors;
		wr(sps_pkg::ADDR_CTRL1, 8'h02);
		dev.send(9'h001, 8, 1'h0, 0);
		wait_clk(150);
		chk_rd(ST, 8'hE7, 8'hFF);
		rd(DT, rv);
		chk_rd(ST, 8'hC0, 8'hFF);
		// odd parity with a matching parity bit must pass clean
		wr(sps_pkg::ADDR_CTRL1, 8'h03);
		dev.send(9'h001, 8, 1'h1, -1);
		wait_clk(150);
		chk_rd(ST, 8'hE0, 8'hFF);
		chk_rd(DT, 8'h01, 8'hFF);
	endtask : t_errors

	// idle is masked here: it may be left over from the errored frame
	task automatic t_nine;
		wr(sps_pkg::ADDR_CTRL1, 8'h10);
		chk_rd(ST, 8'hC0, 8'hEF);
		dev.send(9'h1A5, 9, 1'h1, -1);
		wait_clk(150);
		chk_rd(DT, 8'hA5, 8'hFF);
		chk_rd(ST, 8'hE0, 8'hEF);
		chk_rd(DT, 8'hA5, 8'hFF);
		chk_rd(ST, 8'hE0, 8'hEF);
		rd(DT, rv);
		chk_rd(sps_pkg::ADDR_CTRL3, 8'h80, 8'hFF);
		chk_rd(ST, 8'hC0, 8'hEF);
		wr(sps_pkg::ADDR_CTRL3, 8'h40);
		#1;
		check({7'h0, o_tx_bit8}, 8'h01, "tx bit 8");
		chk_rd(sps_pkg::ADDR_CTRL3, 8'hC0, 8'hFF);
	endtask : t_nine

	// main sequence: reset for five cycles, then every scenario in turn
	initial begin
		mismatches = 0;
		n_compared = 0;
		i_reset_n  = 1'h0;
		i_addr     = 3'h0;
		i_wdata    = 8'h00;
		i_wr       = 1'h0;
		i_rd       = 1'h0;
		i_tx_load  = 1'h0;
		i_tx_busy  = 1'h0;
		wait_clk(5);
		i_reset_n <= 1'h1;
		t_tx();
		t_rx8();
		t_idle1();
		t_overrun();
		t_errors();
		t_nine();
		end_of_test();
	end

	// watchdog sized about a quarter above the roughly 75k cycles of traffic
	initial begin
		wait_clk(95000);
		mismatches++;
		end_of_test();
	end
endmodule : tb_sps_status_flags
